// ===== src/sss_btn_sync.sv
// button synchroniser, debounce and press pulse generator
`timescale 1ns/10ps
`default_nettype none
module sss_btn_sync
  import sss_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [SSS_NBTN-1:0] btn_i,
  output logic [SSS_NBTN-1:0] press_o
);

  genvar g;
  generate
    for (g = 0; g < SSS_NBTN; g++) begin : g_btn
      logic s1_reg, s2_reg, s3_reg, level_reg, press_reg;
      // first stage feeds only the second
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= btn_i[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // a level counts only when two stages agree
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          level_reg <= 1'b0;
          press_reg <= 1'b0;
        end else begin
          press_reg <= 1'b0;
          if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
            press_reg <= s3_reg && !level_reg;
          end
        end
      end
      assign press_o[g] = press_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== src/sss_pkg.sv
// shared constants and types of the status screen sequencer
package sss_pkg;

  // clock and seconds tick
  localparam int unsigned SSS_CLK_HZ = 10_000_000;
  localparam int unsigned SSS_SEC_TIME_S = 1;
  localparam int unsigned SSS_SEC_CYCLES = SSS_CLK_HZ * SSS_SEC_TIME_S;

  // screens and buttons
  localparam int unsigned SSS_NSCREEN = 8;
  localparam int unsigned SSS_NBTN = 5;

  // AHB-Lite register offsets (byte addresses)
  localparam logic [7:0] SSS_CTRL_OFF = 8'h00;
  localparam logic [7:0] SSS_MASK_OFF = 8'h04;
  localparam logic [7:0] SSS_DWELL_OFF = 8'h08;
  localparam logic [7:0] SSS_BRIGHT_OFF = 8'h0C;
  localparam logic [7:0] SSS_TIMEOUT_OFF = 8'h10;
  localparam logic [7:0] SSS_STATUS_OFF = 8'h14;
  localparam logic [7:0] SSS_NVMASK_OFF = 8'h18;
  localparam logic [2:0] SSS_HSIZE_WORD = 3'h2;

  // control register fields
  localparam int unsigned SSS_CTRL_DYN_BIT = 0;
  localparam int unsigned SSS_CTRL_PREC_BIT = 1;
  localparam int unsigned SSS_CTRL_SAV_LSB = 2;
  localparam int unsigned SSS_CTRL_EDIT_BIT = 4;

  // brightness register fields
  localparam int unsigned SSS_BRIGHT_NORM_LSB = 0;
  localparam int unsigned SSS_BRIGHT_SAV_LSB = 8;

  // status register fields
  localparam int unsigned SSS_STAT_SCREEN_LSB = 0;
  localparam int unsigned SSS_STAT_ACTIVE_BIT = 3;
  localparam int unsigned SSS_STAT_LMODE_LSB = 4;
  localparam int unsigned SSS_STAT_CURSOR_LSB = 8;
  localparam int unsigned SSS_STAT_IDLE_LSB = 16;

  // reset values and limits
  localparam logic [7:0] SSS_MASK_RESET = 8'hFF;
  localparam logic [7:0] SSS_MASK_KEEP = 8'h01;
  localparam logic [11:0] SSS_DWELL_MIN = 12'h001;
  localparam logic [11:0] SSS_DWELL_MAX = 12'hE10;
  localparam logic [11:0] SSS_DWELL_RESET = 12'h00A;
  localparam logic [7:0] SSS_NORM_BRIGHT_RESET = 8'h7F;
  localparam logic [6:0] SSS_SAV_BRIGHT_RESET = 7'h3F;
  localparam logic [15:0] SSS_TIMEOUT_RESET = 16'h0384;

  typedef enum logic [1:0] {
    SSS_SAV_DISABLED = 2'h0,
    SSS_SAV_LOW = 2'h1,
    SSS_SAV_SCROLL = 2'h2,
    SSS_SAV_OFF = 2'h3
  } sss_saver_t;

  typedef enum logic [1:0] {
    SSS_SS_IDLE = 2'b01,
    SSS_SS_ACTIVE = 2'b10
  } sss_ss_state_t;

  typedef struct packed {
    logic up;
    logic down;
    logic right;
    logic accept;
    logic esc;
  } sss_btn_t;

endpackage

// ===== src/sss_top.sv
// status screen sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module sss_top
  import sss_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SSS_SEC_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic joystick_up_i,
  input wire logic joystick_down_i,
  input wire logic joystick_right_i,
  input wire logic joystick_accept_i,
  input wire logic escape_i,
  output logic [2:0] screen_o,
  output logic [7:0] brightness_o,
  output logic display_on_o,
  output logic scroll_o,
  output logic precision_elevated_o,
  output logic nv_store_o,
  output logic [7:0] nv_mask_o
);

  localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);

  logic [SSS_NBTN-1:0] press_vec;
  sss_btn_t btn;
  logic activity;

  sss_btn_sync u_sss_btn_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .btn_i({joystick_up_i, joystick_down_i, joystick_right_i, joystick_accept_i, escape_i}),
    .press_o(press_vec)
  );
  assign btn = sss_btn_t'(press_vec);
  assign activity = |press_vec;

  // bus slave: writes zero wait, reads one wait so earlier writes show
  logic wr_pend_reg, rd_pend_reg, rd_done_reg, wr_en;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg, rd_mux;
  logic bus_sel;

  assign bus_sel = hsel_i && htrans_i[1];
  assign wr_en = wr_pend_reg;
  assign hreadyout_o = !(rd_pend_reg && !rd_done_reg);
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready_i) begin
      wr_pend_reg <= bus_sel && hwrite_i && (hsize_i == SSS_HSIZE_WORD);
      rd_pend_reg <= bus_sel && !hwrite_i;
      addr_reg <= haddr_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_done_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      rd_done_reg <= rd_pend_reg && !rd_done_reg;
      if (rd_pend_reg && !rd_done_reg) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // configuration registers
  logic dyn_reg, prec_reg, edit_reg;
  sss_saver_t sav_mode_reg;
  logic [7:0] mask_reg, nv_mask_reg, norm_bright_reg;
  logic [6:0] sav_bright_reg;
  logic [11:0] dwell_reg;
  logic [15:0] timeout_reg;
  logic nv_store_reg;
  logic [2:0] edit_sel_reg, screen_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dyn_reg <= 1'b0;
      prec_reg <= 1'b0;
      edit_reg <= 1'b0;
      sav_mode_reg <= SSS_SAV_SCROLL;
    end else if (wr_en && addr_reg == SSS_CTRL_OFF) begin
      dyn_reg <= hwdata_i[SSS_CTRL_DYN_BIT];
      prec_reg <= hwdata_i[SSS_CTRL_PREC_BIT];
      edit_reg <= hwdata_i[SSS_CTRL_EDIT_BIT];
      sav_mode_reg <= sss_saver_t'(hwdata_i[SSS_CTRL_SAV_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dwell_reg <= SSS_DWELL_RESET;
      norm_bright_reg <= SSS_NORM_BRIGHT_RESET;
      sav_bright_reg <= SSS_SAV_BRIGHT_RESET;
      timeout_reg <= SSS_TIMEOUT_RESET;
    end else if (wr_en) begin
      // out of range dwell values are dropped, old value kept
      if (addr_reg == SSS_DWELL_OFF && hwdata_i[31:12] == 20'h00000 &&
          hwdata_i[11:0] >= SSS_DWELL_MIN && hwdata_i[11:0] <= SSS_DWELL_MAX) begin
        dwell_reg <= hwdata_i[11:0];
      end
      if (addr_reg == SSS_BRIGHT_OFF) begin
        norm_bright_reg <= hwdata_i[SSS_BRIGHT_NORM_LSB +: 8];
        sav_bright_reg <= hwdata_i[SSS_BRIGHT_SAV_LSB +: 7];
      end
      if (addr_reg == SSS_TIMEOUT_OFF) begin
        timeout_reg <= hwdata_i[15:0];
      end
    end
  end

  // mask: bus write wins over a same-cycle toggle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_reg <= SSS_MASK_RESET;
    end else if (wr_en && addr_reg == SSS_MASK_OFF) begin
      mask_reg <= hwdata_i[7:0] | SSS_MASK_KEEP;
    end else if (edit_reg && btn.right && edit_sel_reg != 3'h0) begin
      mask_reg[edit_sel_reg] <= !mask_reg[edit_sel_reg];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edit_sel_reg <= 3'h0;
    end else if (!edit_reg) begin
      edit_sel_reg <= 3'h0;
    end else if (btn.up) begin
      edit_sel_reg <= edit_sel_reg + 3'h1;
    end else if (btn.down) begin
      edit_sel_reg <= edit_sel_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_mask_reg <= SSS_MASK_RESET;
      nv_store_reg <= 1'b0;
    end else begin
      nv_store_reg <= edit_reg && btn.accept;
      if (edit_reg && btn.accept) begin
        nv_mask_reg <= mask_reg;
      end
    end
  end

  // seconds tick divider
  logic [23:0] sec_cnt_reg;
  logic sec_tick_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sec_cnt_reg <= 24'h000000;
      sec_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= (sec_cnt_reg == SEC_LAST);
      sec_cnt_reg <= (sec_cnt_reg == SEC_LAST) ? 24'h000000 : sec_cnt_reg + 24'h000001;
    end
  end

  // next enabled screen search; screen one is always found
  function automatic logic [2:0] sss_step(input logic [7:0] m, input logic [2:0] cur, input logic fwd);
    logic [2:0] idx;
    logic [2:0] res;
    logic found;
    idx = cur;
    res = 3'h0;
    found = 1'b0;
    for (int i = 0; i < SSS_NSCREEN; i++) begin
      idx = fwd ? idx + 3'h1 : idx - 3'h1;
      if (!found && m[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  logic [2:0] nxt_up, nxt_down;
  logic [11:0] dwell_cnt_reg;
  logic dwell_hit, page_ok, dyn_run;

  assign nxt_up = sss_step(mask_reg, screen_reg, 1'b1);
  assign nxt_down = sss_step(mask_reg, screen_reg, 1'b0);
  assign dwell_hit = sec_tick_reg && (dwell_cnt_reg + 12'h001 >= dwell_reg);
  assign page_ok = !dyn_reg && !edit_reg && mask_reg[screen_reg];
  assign dyn_run = dyn_reg && mask_reg[screen_reg];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dwell_cnt_reg <= 12'h000;
    end else if (!dyn_reg || dwell_hit) begin
      dwell_cnt_reg <= 12'h000;
    end else if (sec_tick_reg) begin
      dwell_cnt_reg <= dwell_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      screen_reg <= 3'h0;
    end else if (!mask_reg[screen_reg]) begin
      screen_reg <= 3'h0;
    end else if (page_ok && btn.up) begin
      screen_reg <= nxt_up;
    end else if (page_ok && btn.down) begin
      screen_reg <= nxt_down;
    end else if (dyn_reg && dwell_hit) begin
      screen_reg <= nxt_up;
    end
  end

  // inactivity timer, saturating so it never rolls back under timeout
  logic [15:0] idle_cnt_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_cnt_reg <= 16'h0000;
    end else if (activity) begin
      idle_cnt_reg <= 16'h0000;
    end else if (sec_tick_reg && idle_cnt_reg != 16'hFFFF) begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end

  // saver: mode and level latched at start, so later edits wait
  sss_ss_state_t ss_state_reg;
  sss_saver_t lat_mode_reg;
  logic [6:0] lat_bright_reg;
  logic saver_active;

  assign saver_active = (ss_state_reg == SSS_SS_ACTIVE);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ss_state_reg <= SSS_SS_IDLE;
      lat_mode_reg <= SSS_SAV_SCROLL;
      lat_bright_reg <= SSS_SAV_BRIGHT_RESET;
    end else begin
      unique case (ss_state_reg)
        SSS_SS_IDLE: begin
          if (!activity && sav_mode_reg != SSS_SAV_DISABLED && idle_cnt_reg >= timeout_reg) begin
            ss_state_reg <= SSS_SS_ACTIVE;
            lat_mode_reg <= sav_mode_reg;
            lat_bright_reg <= sav_bright_reg;
          end
        end
        SSS_SS_ACTIVE: begin
          if (activity) begin
            ss_state_reg <= SSS_SS_IDLE;
          end
        end
        default: begin
          ss_state_reg <= SSS_SS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brightness_o <= SSS_NORM_BRIGHT_RESET;
      display_on_o <= 1'b1;
      scroll_o <= 1'b0;
    end else if (!saver_active) begin
      brightness_o <= norm_bright_reg;
      display_on_o <= 1'b1;
      scroll_o <= 1'b0;
    end else begin
      unique case (lat_mode_reg)
        SSS_SAV_LOW: begin
          brightness_o <= {1'b0, lat_bright_reg};
          display_on_o <= 1'b1;
          scroll_o <= 1'b0;
        end
        SSS_SAV_SCROLL: begin
          brightness_o <= norm_bright_reg;
          display_on_o <= 1'b1;
          scroll_o <= 1'b1;
        end
        SSS_SAV_OFF: begin
          brightness_o <= 8'h00;
          display_on_o <= 1'b0;
          scroll_o <= 1'b0;
        end
        SSS_SAV_DISABLED: begin
          brightness_o <= norm_bright_reg;
          display_on_o <= 1'b1;
          scroll_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      screen_o <= 3'h0;
      precision_elevated_o <= 1'b0;
    end else begin
      screen_o <= screen_reg;
      precision_elevated_o <= prec_reg;
    end
  end

  assign nv_store_o = nv_store_reg;
  assign nv_mask_o = nv_mask_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_reg)
      SSS_CTRL_OFF: begin
        rd_mux[SSS_CTRL_DYN_BIT] = dyn_reg;
        rd_mux[SSS_CTRL_PREC_BIT] = prec_reg;
        rd_mux[SSS_CTRL_SAV_LSB +: 2] = sav_mode_reg;
        rd_mux[SSS_CTRL_EDIT_BIT] = edit_reg;
      end
      SSS_MASK_OFF: rd_mux[7:0] = mask_reg;
      SSS_DWELL_OFF: rd_mux[11:0] = dwell_reg;
      SSS_BRIGHT_OFF: begin
        rd_mux[SSS_BRIGHT_NORM_LSB +: 8] = norm_bright_reg;
        rd_mux[SSS_BRIGHT_SAV_LSB +: 7] = sav_bright_reg;
      end
      SSS_TIMEOUT_OFF: rd_mux[15:0] = timeout_reg;
      SSS_STATUS_OFF: begin
        rd_mux[SSS_STAT_SCREEN_LSB +: 3] = screen_reg;
        rd_mux[SSS_STAT_ACTIVE_BIT] = saver_active;
        rd_mux[SSS_STAT_LMODE_LSB +: 2] = lat_mode_reg;
        rd_mux[SSS_STAT_CURSOR_LSB +: 3] = edit_sel_reg;
        rd_mux[SSS_STAT_IDLE_LSB +: 16] = idle_cnt_reg;
      end
      SSS_NVMASK_OFF: rd_mux[7:0] = nv_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // checks
  logic [7:0] mask_prev_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_prev_reg <= SSS_MASK_RESET;
    end else begin
      mask_prev_reg <= mask_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  screen_one_a: assert property (mask_reg[0]) else $error("screen one disabled");
  static_up_a: assert property (page_ok && btn.up |=> screen_reg == $past(nxt_up))
    else $error("up press did not page forward");
  static_down_a: assert property (page_ok && !btn.up && btn.down |=> screen_reg == $past(nxt_down))
    else $error("down press did not page back");
  wrap_up_a: assert property (page_ok && btn.up && mask_reg == 8'hFF && screen_reg == 3'h7 |=> screen_reg == 3'h0)
    else $error("no wrap to first screen");
  skip_off_a: assert property ($changed(screen_reg) |-> mask_prev_reg[screen_reg])
    else $error("landed on disabled screen");
  static_hold_a: assert property (page_ok && !btn.up && !btn.down |=> $stable(screen_reg))
    else $error("static screen moved by itself");
  dwell_step_a: assert property ($past(dyn_run) && $changed(screen_reg) |-> $past(dwell_hit))
    else $error("dynamic step without dwell expiry");
  norm_bright_a: assert property (!saver_active |=> brightness_o == $past(norm_bright_reg) && display_on_o)
    else $error("normal brightness not applied");
  wake_clear_a: assert property (activity |=> idle_cnt_reg == 16'h0000 && !saver_active)
    else $error("activity did not wake display");
  low_bright_a: assert property (saver_active && lat_mode_reg == SSS_SAV_LOW |=> brightness_o == {1'b0, $past(lat_bright_reg)})
    else $error("saver brightness not applied");
  latch_hold_a: assert property (saver_active && $past(saver_active) |-> $stable(lat_mode_reg) && $stable(lat_bright_reg))
    else $error("saver settings changed while active");
  scroll_bright_a: assert property (saver_active && lat_mode_reg == SSS_SAV_SCROLL |=> scroll_o && brightness_o == $past(norm_bright_reg))
    else $error("scroll saver brightness wrong");
  timeout_start_a: assert property (!saver_active && !activity && sav_mode_reg != SSS_SAV_DISABLED &&
      idle_cnt_reg >= timeout_reg |=> saver_active)
    else $error("saver did not start at timeout");
  toggle_bit_a: assert property (edit_reg && btn.right && edit_sel_reg != 3'h0 && !wr_en |=>
      mask_reg[$past(edit_sel_reg)] != $past(mask_reg[edit_sel_reg]))
    else $error("right press did not toggle");
  commit_nv_a: assert property (edit_reg && btn.accept |=> nv_store_o && nv_mask_o == $past(mask_reg))
    else $error("accept did not commit mask");

  wrap_c: cover property (page_ok && btn.up && screen_reg == 3'h7 ##1 screen_reg == 3'h0);
  dyn_step_c: cover property (dyn_reg && dwell_hit ##1 $changed(screen_reg));
  saver_on_c: cover property (!saver_active ##1 saver_active);
  commit_c: cover property (nv_store_o);

endmodule
`default_nettype wire

// ===== verification/sss_panel.sv
// button panel model: presses a button for a fixed time, then releases it
`timescale 1ns/10ps
`default_nettype none
module sss_panel
  import sss_pkg::*;
#(
  parameter int unsigned HOLD = 6
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire sss_btn_t req_i,
  output var sss_btn_t pins_o,
  output logic busy_o
);
  logic [4:0] cnt_reg;
  // high for HOLD+1 cycles then low for HOLD-1 while busy, so the debounce sees a clean press
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 5'h00;
      pins_o <= '0;
    end else if (cnt_reg == 5'h00 && req_i != '0) begin
      pins_o <= req_i;
      cnt_reg <= 5'(2 * HOLD);
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      if (cnt_reg == 5'(HOLD)) begin
        pins_o <= '0;
      end
    end
  end
  assign busy_o = (cnt_reg != 5'h00);
endmodule
`default_nettype wire

// ===== verification/sss_top_bench.sv
// self-checking bench of the status screen sequencer
`timescale 1ns/10ps
`default_nettype none
module sss_top_bench;
  import sss_pkg::*;
  localparam int unsigned SEC = 20;
  logic clk_i = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp;
  logic [31:0] hrdata;
  logic [2:0] screen;
  logic [7:0] bright;
  logic disp_on, scroll, prec, nv_store;
  logic [7:0] nv_mask;
  sss_btn_t req = '0;
  sss_btn_t pins;
  logic busy;
  int errors = 0;
  int samples_checked = 0;
  int nv_pulses = 0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] rv, t0;
  always #50 clk_i = ~clk_i;
  sss_top #(.SEC_CYCLES(SEC)) u_sss_top (.clk_i(clk_i), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .joystick_up_i(pins.up),
    .joystick_down_i(pins.down), .joystick_right_i(pins.right), .joystick_accept_i(pins.accept),
    .escape_i(pins.esc), .screen_o(screen), .brightness_o(bright), .display_on_o(disp_on), .scroll_o(scroll),
    .precision_elevated_o(prec), .nv_store_o(nv_store), .nv_mask_o(nv_mask));
  sss_panel u_sss_panel (.clk_i(clk_i), .reset_n_i(reset_n), .req_i(req), .pins_o(pins), .busy_o(busy));
  task summarize;
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // whole run is under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'd30000) begin
      errors++;
      summarize();
    end
  end
  // commit strobes counted so a missing or doubled pulse shows
  always @(posedge clk_i) begin
    if (nv_store === 1'b1) begin
      nv_pulses <= nv_pulses + 1;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= SSS_HSIZE_WORD;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rv);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, rv);
  endtask
  task press(input sss_btn_t b);
    @(posedge clk_i);
    req <= b;
    @(posedge clk_i);
    req <= '0;
    do @(posedge clk_i); while (busy === 1'b1);
    repeat (2) @(posedge clk_i);
  endtask
  task wait_bright(input logic [7:0] v);
    for (int n = 0; n < 300 && bright !== v; n++) @(posedge clk_i);
  endtask
  task test_reset;
    chk({disp_on, scroll, prec, hresp, nv_mask, bright, 5'h00, screen}, {4'h8, 8'hFF, 8'h7F, 8'h00});
    rd(SSS_CTRL_OFF);
    chk(rv, 32'h08);
    rd(SSS_MASK_OFF);
    chk(rv, 32'hFF);
    rd(SSS_BRIGHT_OFF);
    chk(rv, 32'h3F7F);
    rd(SSS_TIMEOUT_OFF);
    chk(rv, 32'h384);
    rd(8'h1C);
    chk(rv, 32'h0);
  endtask
  task test_paging;
    press('{up: 1'b1, default: 1'b0});
    chk(screen, 3'h1);
    press('{down: 1'b1, default: 1'b0});
    press('{down: 1'b1, default: 1'b0});
    chk(screen, 3'h7);
    press('{up: 1'b1, default: 1'b0});
    chk(screen, 3'h0);
    wr(SSS_MASK_OFF, 32'h00);
    rd(SSS_MASK_OFF);
    chk(rv, 32'h01);
    wr(SSS_MASK_OFF, 32'h05);
    press('{up: 1'b1, default: 1'b0});
    chk(screen, 3'h2);
    press('{up: 1'b1, default: 1'b0});
    chk(screen, 3'h0);
  endtask
  task test_dwell;
    wr(SSS_DWELL_OFF, 32'h000);
    wr(SSS_DWELL_OFF, 32'hE11);
    rd(SSS_DWELL_OFF);
    chk(rv, 32'h00A);
    wr(SSS_DWELL_OFF, 32'hE10);
    rd(SSS_DWELL_OFF);
    chk(rv, 32'hE10);
    wr(SSS_DWELL_OFF, 32'h002);
    wr(SSS_MASK_OFF, 32'h03);
    wr(SSS_CTRL_OFF, 32'h09);
    for (int n = 0; n < 200 && screen !== 3'h1; n++) @(posedge clk_i);
    t0 = cyc;
    for (int n = 0; n < 200 && screen !== 3'h0; n++) @(posedge clk_i);
    chk(cyc - t0, 2 * SEC);
    press('{up: 1'b1, default: 1'b0});
    chk(screen, 3'h0);
    wr(SSS_CTRL_OFF, 32'h08);
    wr(SSS_MASK_OFF, 32'hFF);
  endtask
  task test_edit;
    wr(SSS_CTRL_OFF, 32'h18);
    press('{right: 1'b1, default: 1'b0});
    press('{up: 1'b1, default: 1'b0});
    press('{right: 1'b1, default: 1'b0});
    rd(SSS_MASK_OFF);
    chk(rv, 32'hFD);
    chk(nv_mask, 8'hFF);
    chk(nv_pulses, 32'h0);
    press('{accept: 1'b1, default: 1'b0});
    rd(SSS_NVMASK_OFF);
    chk({rv[7:0], nv_mask}, 16'hFDFD);
    chk(nv_pulses, 32'h1);
    wr(SSS_CTRL_OFF, 32'h0A);
    // output flop follows the control bit one edge after the write lands
    repeat (2) @(posedge clk_i);
    chk(prec, 1'b1);
    wr(SSS_CTRL_OFF, 32'h08);
    wr(SSS_MASK_OFF, 32'hFF);
  endtask
  task test_saver;
    wr(SSS_BRIGHT_OFF, 32'h2155);
    wr(SSS_TIMEOUT_OFF, 32'h3);
    wr(SSS_CTRL_OFF, 32'h04);
    press('{esc: 1'b1, default: 1'b0});
    chk(bright, 8'h55);
    wait_bright(8'h21);
    chk(bright, 8'h21);
    wr(SSS_CTRL_OFF, 32'h0C);
    repeat (3) @(posedge clk_i);
    chk({disp_on, bright}, 9'h121);
    press('{esc: 1'b1, default: 1'b0});
    chk({disp_on, bright}, 9'h155);
    for (int n = 0; n < 300 && disp_on !== 1'b0; n++) @(posedge clk_i);
    chk(disp_on, 1'b0);
    wr(SSS_CTRL_OFF, 32'h08);
    press('{esc: 1'b1, default: 1'b0});
    chk(disp_on, 1'b1);
    for (int n = 0; n < 300 && scroll !== 1'b1; n++) @(posedge clk_i);
    chk({scroll, bright}, 9'h155);
    press('{esc: 1'b1, default: 1'b0});
    chk(scroll, 1'b0);
    wr(SSS_CTRL_OFF, 32'h00);
    repeat (100) @(posedge clk_i);
    chk({scroll, disp_on, bright}, 10'h155);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n <= 1'b1;
    test_reset();
    test_paging();
    test_dwell();
    test_edit();
    test_saver();
    summarize();
  end
endmodule
`default_nettype wire
